// >>> pkg/twi_pkg.sv
// Shared constants and types of the two-wire serial port
package twi_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_STAT = 8'h04;
  localparam logic [APB_AW-1:0] OFS_RCV = 8'h08;
  localparam logic [APB_AW-1:0] OFS_TRN = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_ADDR = 8'h10;
  localparam logic [APB_AW-1:0] OFS_IFLAG = 8'h14;
  localparam logic [APB_AW-1:0] OFS_IMASK = 8'h18;

  // ----------------------------------------------------------------
  // Control field positions and reset value
  // ----------------------------------------------------------------
  localparam int C_EN = 15;
  localparam int C_SIDL = 13;
  localparam int C_REL = 12;
  localparam int C_A10 = 10;
  localparam int C_STRETCH = 6;
  localparam int C_ACKDT = 5;
  localparam int C_ACKREQ = 4;
  localparam int C_RXREQ = 3;
  localparam int C_STOPREQ = 2;
  localparam int C_RESTARTREQ = 1;
  localparam int C_STARTREQ = 0;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  localparam logic [15:0] CTRL_WMASK = 16'hB47F;

  // ----------------------------------------------------------------
  // Status, interrupt and address fields
  // ----------------------------------------------------------------
  localparam int S_START = 3;
  localparam int S_RW = 2;
  localparam int S_RXFULL = 1;
  localparam int S_TXFULL = 0;
  localparam int IRQ_W = 3;
  localparam int IRQ_SLAVE = 0;
  localparam int IRQ_MASTER = 1;
  localparam int IRQ_STOP = 2;
  localparam int BITS = 8;
  localparam logic [4:0] ADDR10_HDR = 5'h1E;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int QUARTER_NS = LINK_PERIOD_NS / 4;
  localparam int QUARTER_CYCLES_RAW = QUARTER_NS / SYS_PERIOD_NS;
  localparam int QUARTER_CYCLES = (QUARTER_CYCLES_RAW < 1) ? 1 : QUARTER_CYCLES_RAW;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_SAMPLE = 2'h2;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SL_IDLE = 3'b000, SL_ADDR = 3'b001, SL_ADDR2 = 3'b010, SL_RX = 3'b011,
    SL_TX = 3'b100, SL_ACK = 3'b101, SL_MACK = 3'b110, SL_SKIP = 3'b111
  } slv_state_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_RESTART = 3'b010, M_STOP = 3'b011,
    M_RECV = 3'b100, M_ACK = 3'b101, M_SEND = 3'b110
  } mop_t;

endpackage

// >>> verilog/twi_sync2.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/10ps
module twi_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> verilog/twi_tick.sv
// Quarter-bit enable pulse divider for the master sequencer
`timescale 1ns/10ps
module twi_tick #(
  parameter int DIV = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;

  // Counter restarts whenever the sequencer is idle so phases start aligned
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// >>> verilog/twi_port.sv
// Two-wire serial port: APB registers, slave engine and master sequencer
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module twi_port
  import twi_pkg::*;
#(
  parameter int QDIV = QUARTER_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  input wire logic IDLE_MODE,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_N,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic start_last;
    logic rw;
    logic rx_full;
    logic tx_full;
    logic [7:0] rcv;
    logic [7:0] trn;
    logic [9:0] addr;
    logic [IRQ_W-1:0] iflag;
    logic [IRQ_W-1:0] imask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic scl_d;
    logic sda_d;
    slv_state_t sst;
    slv_state_t after;
    logic [3:0] scnt;
    logic [7:0] shift;
    logic wide_ok;
    logic sda_low_s;
    mop_t mop;
    logic [1:0] mph;
    logic [3:0] mbit;
    logic [7:0] mshift;
    logic mown;
    logic mscl_low;
    logic msda_low;
    logic scl_oe_n;
    logic sda_oe_n;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic scl_s;
  logic sda_s;
  logic tick;

  // ----------------------------------------------------------------
  // Pin synchronisers and quarter-bit divider
  // ----------------------------------------------------------------
  twi_sync2 #(.WIDTH(1)) u_sync_scl (.clk(SYS_CLK), .rst(RST), .d(SCL_IN), .q(scl_s));
  twi_sync2 #(.WIDTH(1)) u_sync_sda (.clk(SYS_CLK), .rst(RST), .d(SDA_IN), .q(sda_s));
  twi_tick #(.DIV(QDIV)) u_tick (
    .clk(SYS_CLK),
    .rst(RST),
    .run(s_reg.mop != M_IDLE),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Master pin pattern: {scl_low, sda_low} per op and phase
  // ----------------------------------------------------------------
  function automatic logic [1:0] drive(input mop_t op, input logic [1:0] ph, input logic b);
    logic [1:0] r;
    r = 2'b00;
    unique case (op)
      M_START: r = (ph == 2'h0) ? 2'b00 : (ph == 2'h1) ? 2'b01 : 2'b11;
      M_RESTART: r = (ph == 2'h0) ? 2'b10 : (ph == 2'h1) ? 2'b00 :
                     (ph == 2'h2) ? 2'b01 : 2'b11;
      M_STOP: r = (ph == 2'h0) ? 2'b11 : (ph == 2'h1) ? 2'b01 : 2'b00;
      M_IDLE: r = 2'b00;
      default: r = {(ph == 2'h0) || (ph == PH_LAST), !b};
    endcase
    return r;
  endfunction

  function automatic logic [3:0] mlast(input mop_t op);
    logic [3:0] r;
    r = 4'h0;
    if (op == M_SEND) begin
      r = 4'(BITS);
    end else if (op == M_RECV) begin
      r = 4'(BITS - 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic acc;
    logic commit;
    logic wr;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic en;
    logic halted;
    logic hit;
    logic hold;
    logic bitv;
    logic mapped;
    logic [31:0] rd;
    logic [2:0] tx_idx;
    logic [2:0] m_idx;
    acc = PSEL && PENABLE;
    commit = acc && s_reg.pready;
    wr = commit && PWRITE;
    rise = scl_s && !s_reg.scl_d;
    fall = !scl_s && s_reg.scl_d;
    start_c = scl_s && s_reg.scl_d && s_reg.sda_d && !sda_s;
    stop_c = scl_s && s_reg.scl_d && !s_reg.sda_d && sda_s;
    en = s_reg.ctrl[C_EN];
    halted = s_reg.ctrl[C_SIDL] && IDLE_MODE;
    hit = 1'b0;
    hold = 1'b0;
    bitv = 1'b1;
    tx_idx = 3'(BITS - 1) - s_reg.scnt[2:0];
    m_idx = 3'(BITS - 1) - s_reg.mbit[2:0];
    s_next = s_reg;
    s_next.scl_d = scl_s;
    s_next.sda_d = sda_s;

    // Register read mux; unmapped addresses answer with an error
    mapped = 1'b1;
    rd = '0;
    unique case (PADDR)
      OFS_CTRL: rd = 32'(s_reg.ctrl);
      OFS_STAT: rd = 32'({s_reg.start_last, s_reg.rw, s_reg.rx_full, s_reg.tx_full});
      OFS_RCV: rd = 32'(s_reg.rcv);
      OFS_TRN: rd = 32'(s_reg.trn);
      OFS_ADDR: rd = 32'(s_reg.addr);
      OFS_IFLAG: rd = 32'(s_reg.iflag);
      OFS_IMASK: rd = 32'(s_reg.imask);
      default: mapped = 1'b0;
    endcase

    // ----------------------------------------------------------------
    // APB slave: one wait state, effects at the completing edge
    // ----------------------------------------------------------------
    s_next.pready = acc && !s_reg.pready;
    s_next.pslverr = acc && !s_reg.pready && !mapped;
    if (acc && !s_reg.pready) begin
      s_next.prdata = rd;
    end
    if (wr) begin
      unique case (PADDR)
        OFS_CTRL: begin
          s_next.ctrl = (PWDATA[15:0] & CTRL_WMASK) | (s_reg.ctrl & ~CTRL_WMASK);
          if (!s_reg.ctrl[C_STRETCH]) begin
            s_next.ctrl[C_REL] = s_reg.ctrl[C_REL] | PWDATA[C_REL];
          end
        end
        OFS_TRN: begin
          s_next.trn = PWDATA[7:0];
          s_next.tx_full = 1'b1;
        end
        OFS_ADDR: s_next.addr = PWDATA[9:0];
        OFS_IFLAG: s_next.iflag = s_reg.iflag & ~PWDATA[IRQ_W-1:0];
        OFS_IMASK: s_next.imask = PWDATA[IRQ_W-1:0];
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    if (commit && !PWRITE && (PADDR == OFS_RCV)) begin
      s_next.rx_full = 1'b0;
    end

    // ----------------------------------------------------------------
    // Bus engines; hardware sets below override software clears above
    // ----------------------------------------------------------------
    if (!en) begin
      s_next.sst = SL_IDLE;
      s_next.mop = M_IDLE;
      s_next.mown = 1'b0;
      s_next.mscl_low = 1'b0;
      s_next.msda_low = 1'b0;
      s_next.sda_low_s = 1'b0;
      s_next.wide_ok = 1'b0;
    end else if (!halted) begin
      // Slave side
      if (stop_c) begin
        s_next.sst = SL_IDLE;
        s_next.start_last = 1'b0;
        s_next.wide_ok = 1'b0;
        s_next.sda_low_s = 1'b0;
        s_next.iflag[IRQ_STOP] = 1'b1;
      end else if (start_c) begin
        s_next.start_last = 1'b1;
        s_next.sst = (s_reg.mown || (s_reg.mop != M_IDLE)) ? SL_IDLE : SL_ADDR;
        s_next.scnt = '0;
        s_next.sda_low_s = 1'b0;
      end else begin
        unique case (s_reg.sst)
          SL_ADDR, SL_ADDR2, SL_RX: begin
            if (rise) begin
              s_next.shift = {s_reg.shift[6:0], sda_s};
              s_next.scnt = s_reg.scnt + 4'h1;
            end
            if (fall && (s_reg.scnt == 4'(BITS))) begin
              s_next.scnt = '0;
              s_next.sst = SL_ACK;
              s_next.sda_low_s = 1'b1;
              if (s_reg.sst == SL_RX) begin
                s_next.rcv = s_reg.shift;
                s_next.rx_full = 1'b1;
                s_next.iflag[IRQ_SLAVE] = 1'b1;
                s_next.after = SL_RX;
                if (s_reg.ctrl[C_STRETCH]) begin
                  s_next.ctrl[C_REL] = 1'b0;
                end
              end else if (s_reg.sst == SL_ADDR2) begin
                hit = s_reg.shift == s_reg.addr[7:0];
                s_next.wide_ok = hit;
                s_next.after = SL_RX;
              end else begin
                if (s_reg.ctrl[C_A10]) begin
                  hit = (s_reg.shift[7:3] == ADDR10_HDR) &&
                        (s_reg.shift[2:1] == s_reg.addr[9:8]) &&
                        (!s_reg.shift[0] || s_reg.wide_ok);
                end else begin
                  hit = s_reg.shift[7:1] == s_reg.addr[6:0];
                end
                if (hit) begin
                  s_next.rw = s_reg.shift[0];
                end
                if (s_reg.shift[0]) begin
                  s_next.after = SL_TX;
                end else begin
                  s_next.after = s_reg.ctrl[C_A10] ? SL_ADDR2 : SL_RX;
                end
              end
              if (s_reg.sst != SL_RX) begin
                s_next.iflag[IRQ_SLAVE] = s_reg.iflag[IRQ_SLAVE] | hit;
                if (!hit) begin
                  s_next.sst = SL_SKIP;
                  s_next.sda_low_s = 1'b0;
                end
              end
            end
          end
          SL_ACK: begin
            if (fall) begin
              s_next.sda_low_s = 1'b0;
              s_next.sst = s_reg.after;
              if (s_reg.after == SL_TX) begin
                s_next.ctrl[C_REL] = 1'b0;
              end
            end
          end
          SL_TX: begin
            // Next bit goes out on the fall itself, so it settles well before the rise
            if (fall) begin
              s_next.scnt = s_reg.scnt + 4'h1;
            end
            tx_idx = 3'(BITS - 1) - s_next.scnt[2:0];
            if (!scl_s) begin
              s_next.sda_low_s = !s_reg.trn[tx_idx];
            end
            if (fall && (s_reg.scnt == 4'(BITS - 1))) begin
              s_next.scnt = '0;
              s_next.sst = SL_MACK;
              s_next.sda_low_s = 1'b0;
              s_next.tx_full = wr && (PADDR == OFS_TRN);
              s_next.iflag[IRQ_SLAVE] = 1'b1;
            end
          end
          SL_MACK: begin
            if (rise) begin
              s_next.shift[0] = sda_s;
            end
            if (fall) begin
              if (!s_reg.shift[0]) begin
                s_next.sst = SL_TX;
                s_next.ctrl[C_REL] = 1'b0;
              end else begin
                s_next.sst = SL_SKIP;
              end
            end
          end
          SL_IDLE, SL_SKIP: s_next.sst = s_reg.sst;
        endcase
      end

      // Master sequencer; requests are served one at a time by priority
      if (s_reg.mop == M_IDLE) begin
        s_next.mph = '0;
        s_next.mbit = '0;
        if (s_reg.ctrl[C_STARTREQ]) begin
          s_next.mop = M_START;
        end else if (s_reg.ctrl[C_RESTARTREQ]) begin
          s_next.mop = M_RESTART;
        end else if (s_reg.ctrl[C_STOPREQ]) begin
          s_next.mop = M_STOP;
        end else if (s_reg.ctrl[C_RXREQ]) begin
          s_next.mop = M_RECV;
        end else if (s_reg.ctrl[C_ACKREQ]) begin
          s_next.mop = M_ACK;
        end else if (s_reg.tx_full && s_reg.mown) begin
          s_next.mop = M_SEND;
        end
      end else if (tick) begin
        if ((s_reg.mph == PH_SAMPLE) && (s_reg.mop == M_RECV)) begin
          s_next.mshift = {s_reg.mshift[6:0], sda_s};
        end
        if (s_reg.mph != PH_LAST) begin
          s_next.mph = s_reg.mph + 2'h1;
        end else if (s_reg.mbit != mlast(s_reg.mop)) begin
          s_next.mph = '0;
          s_next.mbit = s_reg.mbit + 4'h1;
        end else begin
          s_next.mop = M_IDLE;
          s_next.iflag[IRQ_MASTER] = 1'b1;
          unique case (s_reg.mop)
            M_START: begin
              s_next.ctrl[C_STARTREQ] = 1'b0;
              s_next.mown = 1'b1;
            end
            M_RESTART: s_next.ctrl[C_RESTARTREQ] = 1'b0;
            M_STOP: begin
              s_next.ctrl[C_STOPREQ] = 1'b0;
              s_next.mown = 1'b0;
            end
            M_RECV: begin
              s_next.ctrl[C_RXREQ] = 1'b0;
              s_next.rcv = s_next.mshift;
              s_next.rx_full = 1'b1;
            end
            M_ACK: s_next.ctrl[C_ACKREQ] = 1'b0;
            default: s_next.tx_full = wr && (PADDR == OFS_TRN);
          endcase
        end
      end
      if (s_next.mop != M_IDLE) begin
        if (s_next.mop == M_SEND) begin
          m_idx = 3'(BITS - 1) - s_next.mbit[2:0];
          bitv = (s_next.mbit < 4'(BITS)) ? s_reg.trn[m_idx] : 1'b1;
        end else if (s_next.mop == M_ACK) begin
          bitv = s_reg.ctrl[C_ACKDT];
        end
        {s_next.mscl_low, s_next.msda_low} = drive(s_next.mop, s_next.mph, bitv);
      end
    end

    // Clock stretch only starts while the line is already low
    hold = !s_next.ctrl[C_REL] && !scl_s &&
           (s_next.sst inside {SL_RX, SL_TX, SL_ACK, SL_MACK});
    s_next.scl_oe_n = !(en && (s_next.mscl_low || hold));
    s_next.sda_oe_n = !(en && (s_next.msda_low || s_next.sda_low_s));
    // Halted port keeps its pins where they were
    if (en && halted) begin
      s_next.scl_oe_n = s_reg.scl_oe_n;
      s_next.sda_oe_n = s_reg.sda_oe_n;
    end
    s_next.irq = |(s_next.iflag & s_next.imask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.sst <= SL_IDLE;
      s_reg.after <= SL_IDLE;
      s_reg.mop <= M_IDLE;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
      s_reg.scl_oe_n <= 1'b1;
      s_reg.sda_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA = s_reg.prdata;
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign IRQ = s_reg.irq;
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE_N = s_reg.scl_oe_n;
  assign SDA_OE_N = s_reg.sda_oe_n;

endmodule

// >>> tb/twi_port_asserts.sv
// Concurrent checks on the pins of the two-wire port
`timescale 1ns/10ps
module twi_port_asserts
  import twi_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ,
  input wire logic IDLE_MODE,
  input wire logic SCL_OUT,
  input wire logic SCL_OE_N,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N
);
  // ----------------------------------------
  // Shadow of the control and mask bits
  // ----------------------------------------
  logic en;
  logic sidl;
  logic [IRQ_W-1:0] mask;
  wire wr_q = PSEL && PENABLE && PWRITE && PREADY;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      {en, sidl, mask} <= 5'h00;
    end else if (wr_q && PADDR == OFS_CTRL) begin
      {en, sidl} <= {PWDATA[C_EN], PWDATA[C_SIDL]};
    end else if (wr_q && PADDR == OFS_IMASK) begin
      mask <= PWDATA[IRQ_W-1:0];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rdy_wait;
    PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready missing after wait state");
  property p_rdy_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_rdy_cause;
    PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access phase");
  property p_err_map;
    PREADY |-> PSLVERR == (PADDR > OFS_IMASK);
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag does not match address");
  property p_ctl_upper;
    PREADY && !PWRITE && PADDR == OFS_CTRL |-> PRDATA[31:16] == 16'h0000 && !PRDATA[14];
  endproperty
  a_ctl_upper: assert property (p_ctl_upper) else $error("control unused bits not zero");
  property p_off;
    !en [*3] |-> SCL_OE_N && SDA_OE_N;
  endproperty
  a_off: assert property (p_off) else $error("pin pulled while disabled");
  property p_idle;
    (sidl && en && IDLE_MODE) [*3] |-> $stable(SCL_OE_N) && $stable(SDA_OE_N);
  endproperty
  a_idle: assert property (p_idle) else $error("pins moved while halted");
  property p_irq_mask;
    (mask == 3'h0) [*2] |-> !IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt with all masked");
  property p_od_low;
    !SCL_OUT && !SDA_OUT;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain data not low");
  c_err: cover property (PREADY && PSLVERR);
  c_irq: cover property ($rose(IRQ));
  c_idle: cover property (sidl && en && IDLE_MODE);
  c_hold: cover property ($fell(SCL_OE_N));
endmodule

bind twi_port twi_port_asserts u_twi_port_asserts (
  .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .IRQ(IRQ), .IDLE_MODE(IDLE_MODE), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N)
);

// >>> tb/twi_bus_model.sv
// Behavioural bus master that drives the serial lines
`timescale 1ns/10ps
module twi_bus_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_n,
  output logic sda_n
);
  // ----------------------------------------
  // 200 ns bits, clock parked high between frames
  // ----------------------------------------
  localparam int Q = 50;
  initial begin
    scl_n = 1'b1;
    sda_n = 1'b1;
  end
  // Waits on the wire itself, so a stretching slave is honoured
  task automatic bit_io(input logic b, output logic got);
    sda_n = b;
    #(Q);
    scl_n = 1'b1;
    wait (scl === 1'b1);
    #(Q);
    got = sda;
    #(Q);
    scl_n = 1'b0;
    #(Q);
  endtask
  task automatic start();
    sda_n = 1'b1;
    #(Q);
    scl_n = 1'b1;
    wait (scl === 1'b1);
    #(Q);
    sda_n = 1'b0;
    #(Q);
    scl_n = 1'b0;
    #(Q);
  endtask
  task automatic stop();
    sda_n = 1'b0;
    #(Q);
    scl_n = 1'b1;
    wait (scl === 1'b1);
    #(Q);
    sda_n = 1'b1;
    #(2*Q);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic got;
    for (int i = 7; i >= 0; i--) bit_io(v[i], got);
    bit_io(1'b1, got);
    ack = !got;
  endtask
  // Ends with a release, so the slave sees no acknowledge and lets go
  task automatic rbyte(output logic [7:0] v);
    logic got;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(1'b1, got);
  endtask
endmodule

// >>> tb/twi_port_tb.sv
// Self-checking bench for the two-wire port
`timescale 1ns/10ps
module twi_port_tb import twi_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic idle_mode = 1'b0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, scl_out, scl_oe_n, sda_out, sda_oe_n, m_scl_n, m_sda_n, err;
  // Line levels settle just off the clock edge so sampling never races them
  wire #3 scl_w = scl_oe_n & m_scl_n;
  wire #3 sda_w = sda_oe_n & m_sda_n;
  int n_errors = 0;
  int checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  twi_port u_twi_port (
    .SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .IDLE_MODE(idle_mode), .SCL_IN(scl_w), .SCL_OUT(scl_out),
    .SCL_OE_N(scl_oe_n), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n)
  );
  twi_bus_model u_twi_bus_model (.scl(scl_w), .sda(sda_w), .scl_n(m_scl_n), .sda_n(m_sda_n));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // Bounded wait for a register to reach a value
  task automatic poll(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    for (int n = 0; n < 100 && r !== e; n++) apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic send(input logic [7:0] b, input logic ack);
    logic got;
    u_twi_bus_model.wbyte(b, got);
    chk({31'h0, got}, {31'h0, ack});
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    rd(OFS_CTRL, {16'h0, CTRL_RESET});
    rd(OFS_STAT, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, r);
    chk({r[30:0], err}, 32'h1);
    wr(OFS_CTRL, 32'h9040);
    wr(OFS_CTRL, 32'h8040);
    rd(OFS_CTRL, 32'h8040);
    wr(OFS_CTRL, 32'h9000);
    wr(OFS_CTRL, 32'h8000);
    rd(OFS_CTRL, 32'h9000);
    $display("register test done");
  endtask
  task automatic t_rx();
    wr(OFS_ADDR, 32'h2A);
    wr(OFS_IMASK, 32'h1);
    u_twi_bus_model.start();
    send(8'h54, 1'b1);
    send(8'hA5, 1'b1);
    u_twi_bus_model.stop();
    rd(OFS_STAT, 32'h2);
    irq_is(1'b1);
    rd(OFS_RCV, 32'hA5);
    rd(OFS_STAT, 32'h0);
    wr(OFS_IMASK, 32'h0);
    irq_is(1'b0);
    wr(OFS_IFLAG, 32'h7);
    wr(OFS_IMASK, 32'h1);
    irq_is(1'b0);
    $display("slave receive test done");
  endtask
  task automatic t_tx();
    logic [7:0] d;
    fork
      begin
        u_twi_bus_model.start();
        send(8'h55, 1'b1);
        u_twi_bus_model.rbyte(d);
        u_twi_bus_model.stop();
      end
      begin
        repeat (200) @(posedge sys_clk);
        chk({31'h0, scl_oe_n}, 32'h0);
        rd(OFS_STAT, 32'hC);
        wr(OFS_TRN, 32'h3C);
        rd(OFS_STAT, 32'hD);
        wr(OFS_CTRL, 32'h9000);
      end
    join
    chk({24'h0, d}, 32'h3C);
    rd(OFS_STAT, 32'h4);
    $display("slave transmit test done");
  endtask
  task automatic t_wide();
    wr(OFS_CTRL, 32'h9400);
    u_twi_bus_model.start();
    send(8'h54, 1'b0);
    u_twi_bus_model.stop();
    u_twi_bus_model.start();
    send(8'hF0, 1'b1);
    send(8'h2A, 1'b1);
    send(8'h5A, 1'b1);
    u_twi_bus_model.stop();
    rd(OFS_RCV, 32'h5A);
    wr(OFS_CTRL, 32'h1000);
    u_twi_bus_model.start();
    send(8'h54, 1'b0);
    u_twi_bus_model.stop();
    $display("address width test done");
  endtask
  task automatic t_master();
    wr(OFS_CTRL, 32'hB000);
    wr(OFS_CTRL, 32'hB001);
    idle_mode <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk({30'h0, scl_w, sda_w}, 32'h3);
    idle_mode <= 1'b0;
    poll(OFS_CTRL, 32'hB000);
    rd(OFS_STAT, 32'h8);
    wr(OFS_CTRL, 32'hB008);
    poll(OFS_CTRL, 32'hB000);
    rd(OFS_RCV, 32'hFF);
    wr(OFS_CTRL, 32'hB002);
    poll(OFS_CTRL, 32'hB000);
    rd(OFS_STAT, 32'h8);
    wr(OFS_CTRL, 32'hB004);
    poll(OFS_CTRL, 32'hB000);
    rd(OFS_STAT, 32'h0);
    $display("master sequence test done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_rx();
    t_tx();
    t_wide();
    t_master();
    final_report();
  end
  // Whole run needs well under 100 us
  initial begin
    #400_000;
    n_errors++;
    final_report();
  end
endmodule
